//--- shared/synth_prog_pkg.sv
package synth_prog_pkg;

  // Address codes in the low four bits of every word
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CAL  = 4'h1;
  localparam logic [3:0] ADDR_DIV  = 4'h2;
  localparam int         ADDR_W    = 4;
  localparam int         WORD_W    = 32;

  // Control word layout
  localparam int CAL_REQ_BIT  = 31;
  localparam int PULSE_BIT    = 30;
  localparam int HIZ_BIT      = 29;
  localparam int POL_BIT      = 28;
  localparam int BACKLASH_LSB = 26;
  localparam int REF_DIV_LSB  = 12;
  localparam int REF_DIV_W    = 14;
  localparam int DRV_OFF_BIT  = 11;
  localparam int DRV_SRC_BIT  = 10;
  localparam int OMODE_LSB    = 8;
  localparam int PUMP_CUR_LSB = 5;
  localparam int SOFT_RST_BIT = 4;

  // Calibration word layout
  localparam int START_BIT    = 31;
  localparam int VCO_LSB      = 18;
  localparam int VCO_W        = 13;
  localparam int REF_INT_LSB  = 11;
  localparam int REF_HUND_LSB = 4;
  localparam int REF_PART_W   = 7;

  // Divider word layout
  localparam int APPLY_BIT    = 29;
  localparam int OBS_LSB      = 25;
  localparam int B_LSB        = 12;
  localparam int B_W          = 13;
  localparam int A_LSB        = 6;
  localparam int A_W          = 6;
  localparam int PSC_LSB      = 4;
  localparam logic [3:0] OBS_LOCK = 4'h6;

  // Decoded values
  localparam logic [11:0] BACKLASH_PS_00 = 12'h5DC;
  localparam logic [11:0] BACKLASH_PS_01 = 12'h384;
  localparam logic [11:0] BACKLASH_PS_10 = 12'hED8;
  localparam logic [11:0] BACKLASH_PS_11 = 12'hA8C;
  localparam logic [6:0]  MOD_8          = 7'h08;
  localparam logic [6:0]  MOD_16         = 7'h10;
  localparam logic [6:0]  MOD_32         = 7'h20;
  localparam logic [6:0]  MOD_64         = 7'h40;
  localparam logic [2:0]  ODIV_1         = 3'h1;
  localparam logic [2:0]  ODIV_2         = 3'h2;
  localparam logic [2:0]  ODIV_4         = 3'h4;

  // Calibration time
  localparam int CAL_TIME_US     = 5000;
  localparam int CLK_MHZ         = 250;
  localparam int CAL_CYCLES_DFLT = CAL_TIME_US * CLK_MHZ;
  localparam int CAL_CNT_W       = 21;

  typedef struct packed {
    logic        pump_pulse_test;
    logic        pump_output_hiz;
    logic        detector_polarity;
    logic [1:0]  antibacklash_width;
    logic [13:0] input_divider_ratio;
    logic        output_driver_off;
    logic        driver_control_source;
    logic [1:0]  output_mode;
    logic [2:0]  pump_current_select;
  } ctrl_fields_t;

  typedef struct packed {
    logic        start;
    logic [12:0] target_vco_mhz;
    logic [6:0]  input_clock_mhz;
    logic [6:0]  input_clock_hundredths;
  } cal_fields_t;

  typedef struct packed {
    logic        apply_and_lock;
    logic [3:0]  observe_select;
    logic [12:0] b_count;
    logic [5:0]  a_count;
    logic [1:0]  dual_modulus_select;
  } div_fields_t;

  typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;
  typedef enum logic {LK_IDLE, LK_WAIT} lock_state_t;

  localparam ctrl_fields_t CTRL_RST = '{input_divider_ratio: 14'h0001, default: '0};
  localparam cal_fields_t  CAL_RST  = '{default: '0};
  localparam div_fields_t  DIV_RST  = '{b_count: 13'h0003, default: '0};

endpackage : synth_prog_pkg

//--- design/serial_word_shifter.sv
`timescale 1ns/1ps
`default_nettype none

module serial_word_shifter #(
  parameter int WIDTH = 32
) (
  input  wire logic             ser_clk_in,
  input  wire logic             ser_data_in,
  output logic      [WIDTH-1:0] word_out
);

  typedef struct packed {
    logic [WIDTH-1:0] sreg;
  } shift_state_t;

  shift_state_t st_r;
  shift_state_t st_nxt;

  generate
    if (WIDTH < 5) begin : g_bad_width
      $error("serial_word_shifter: WIDTH too small");
    end
  endgenerate

  // Link clock stops between frames, so no reset here
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sreg = {ser_data_in, st_r.sreg[WIDTH-1:1]};
  end

  always_ff @(posedge ser_clk_in) begin
    st_r <= st_nxt;
  end

  assign word_out = st_r.sreg;

endmodule : serial_word_shifter

`default_nettype wire

//--- design/synth_prog_regs.sv
`timescale 1ns/1ps
`default_nettype none

module synth_prog_regs #(
  parameter int unsigned CAL_CYCLES = synth_prog_pkg::CAL_CYCLES_DFLT
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      ser_clk_in,
  input  wire logic                      ser_data_in,
  input  wire logic                      ser_load_in,
  input  wire logic                      lock_raw_in,
  input  wire logic                      driver_enable_pin_in,
  output logic                           cal_required_out,
  output logic                           cal_busy_out,
  output synth_prog_pkg::ctrl_fields_t   ctrl_out,
  output synth_prog_pkg::cal_fields_t    cal_out,
  output synth_prog_pkg::div_fields_t    div_out,
  output logic                    [12:0] b_active_out,
  output logic                    [5:0]  a_active_out,
  output logic                    [6:0]  modulus_active_out,
  output logic                    [11:0] antibacklash_ps_out,
  output logic                    [2:0]  output_divide_out,
  output logic                           driver_on_out,
  output logic                           lock_detect_out
);

  localparam int CNT_W = synth_prog_pkg::CAL_CNT_W;
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);

  generate
    if (CAL_CYCLES < 1 || CAL_CYCLES > (2 ** CNT_W)) begin : g_bad_cal
      $error("synth_prog_regs: CAL_CYCLES out of counter range");
    end
  endgenerate

  typedef struct packed {
    logic [2:0]                   strobe_sync;
    logic [1:0]                   lock_sync;
    logic [1:0]                   pin_sync;
    synth_prog_pkg::ctrl_fields_t ctrl;
    synth_prog_pkg::cal_fields_t  cal;
    synth_prog_pkg::div_fields_t  div;
    logic [12:0]                  b_act;
    logic [5:0]                   a_act;
    logic [6:0]                   mod_act;
    synth_prog_pkg::cal_state_t   cal_st;
    logic [CNT_W-1:0]             cal_cnt;
    logic                         cal_required;
    synth_prog_pkg::lock_state_t  lk_st;
    logic                         lock_pin;
    logic                         driver_on;
    logic [2:0]                   out_div;
    logic [11:0]                  backlash_ps;
  } state_t;

  state_t      st_r;
  state_t      st_nxt;
  logic [31:0] word;
  logic        load;
  logic [3:0]  addr;
  logic [6:0]  mod_dec;

  ////////////////////////////////////////////////////////////////////////////
  // Link side

  serial_word_shifter #(
    .WIDTH (synth_prog_pkg::WORD_W)
  ) u_shifter (
    .ser_clk_in  (ser_clk_in),
    .ser_data_in (ser_data_in),
    .word_out    (word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strobe edge; serial clock is idle while the strobe rises, so the word is stable

  assign load = st_r.strobe_sync[1] & ~st_r.strobe_sync[2];
  assign addr = word[synth_prog_pkg::ADDR_W-1:0];

  always_comb begin
    case (word[synth_prog_pkg::PSC_LSB +: 2])
      2'h0:    mod_dec = synth_prog_pkg::MOD_8;
      2'h1:    mod_dec = synth_prog_pkg::MOD_16;
      2'h2:    mod_dec = synth_prog_pkg::MOD_32;
      default: mod_dec = synth_prog_pkg::MOD_64;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt             = st_r;
    st_nxt.strobe_sync = {st_r.strobe_sync[1:0], ser_load_in};
    st_nxt.lock_sync   = {st_r.lock_sync[0], lock_raw_in};
    st_nxt.pin_sync    = {st_r.pin_sync[0], driver_enable_pin_in};

    // Calibration timer
    case (st_r.cal_st)
      synth_prog_pkg::CAL_IDLE: begin
        st_nxt.cal_cnt = '0;
      end
      synth_prog_pkg::CAL_RUN: begin
        if (st_r.cal_cnt == CAL_LAST) begin
          st_nxt.cal_st       = synth_prog_pkg::CAL_IDLE;
          st_nxt.cal.start    = 1'b0;
          st_nxt.cal_required = 1'b0;
          st_nxt.cal_cnt      = '0;
        end else begin
          st_nxt.cal_cnt = st_r.cal_cnt + 1'b1;
        end
      end
      default: st_nxt.cal_st = synth_prog_pkg::CAL_IDLE;
    endcase

    // Apply bit waits for lock
    case (st_r.lk_st)
      synth_prog_pkg::LK_IDLE: ;
      synth_prog_pkg::LK_WAIT: begin
        if (st_r.lock_sync[1]) begin
          st_nxt.lk_st              = synth_prog_pkg::LK_IDLE;
          st_nxt.div.apply_and_lock = 1'b0;
        end
      end
      default: st_nxt.lk_st = synth_prog_pkg::LK_IDLE;
    endcase

    // Writes come last so a new write wins over the apply bit self clear
    if (load) begin
      case (addr)
        synth_prog_pkg::ADDR_CTRL: begin
          if (word[synth_prog_pkg::SOFT_RST_BIT]) begin
            st_nxt.ctrl    = synth_prog_pkg::CTRL_RST;
            st_nxt.cal     = synth_prog_pkg::CAL_RST;
            st_nxt.div     = synth_prog_pkg::DIV_RST;
            st_nxt.b_act   = synth_prog_pkg::DIV_RST.b_count;
            st_nxt.a_act   = synth_prog_pkg::DIV_RST.a_count;
            st_nxt.mod_act = synth_prog_pkg::MOD_8;
            st_nxt.cal_st  = synth_prog_pkg::CAL_IDLE;
            st_nxt.cal_cnt = '0;
            st_nxt.lk_st   = synth_prog_pkg::LK_IDLE;
          end else begin
            st_nxt.ctrl.pump_pulse_test       = word[synth_prog_pkg::PULSE_BIT];
            st_nxt.ctrl.pump_output_hiz       = word[synth_prog_pkg::HIZ_BIT];
            st_nxt.ctrl.detector_polarity     = word[synth_prog_pkg::POL_BIT];
            st_nxt.ctrl.antibacklash_width    = word[synth_prog_pkg::BACKLASH_LSB +: 2];
            st_nxt.ctrl.input_divider_ratio   =
              word[synth_prog_pkg::REF_DIV_LSB +: synth_prog_pkg::REF_DIV_W];
            st_nxt.ctrl.output_driver_off     = word[synth_prog_pkg::DRV_OFF_BIT];
            st_nxt.ctrl.driver_control_source = word[synth_prog_pkg::DRV_SRC_BIT];
            st_nxt.ctrl.output_mode           = word[synth_prog_pkg::OMODE_LSB +: 2];
            st_nxt.ctrl.pump_current_select   = word[synth_prog_pkg::PUMP_CUR_LSB +: 3];
          end
        end
        synth_prog_pkg::ADDR_CAL: begin
          if (st_r.cal_st != synth_prog_pkg::CAL_RUN) begin
            st_nxt.cal.start                  = word[synth_prog_pkg::START_BIT];
            st_nxt.cal.target_vco_mhz         =
              word[synth_prog_pkg::VCO_LSB +: synth_prog_pkg::VCO_W];
            st_nxt.cal.input_clock_mhz        =
              word[synth_prog_pkg::REF_INT_LSB +: synth_prog_pkg::REF_PART_W];
            st_nxt.cal.input_clock_hundredths =
              word[synth_prog_pkg::REF_HUND_LSB +: synth_prog_pkg::REF_PART_W];
            if (word[synth_prog_pkg::START_BIT]) begin
              st_nxt.cal_st  = synth_prog_pkg::CAL_RUN;
              st_nxt.cal_cnt = '0;
            end
          end
        end
        synth_prog_pkg::ADDR_DIV: begin
          if (st_r.cal_st != synth_prog_pkg::CAL_RUN) begin
            st_nxt.div.apply_and_lock      = word[synth_prog_pkg::APPLY_BIT];
            st_nxt.div.observe_select      = word[synth_prog_pkg::OBS_LSB +: 4];
            st_nxt.div.b_count             = word[synth_prog_pkg::B_LSB +: synth_prog_pkg::B_W];
            st_nxt.div.a_count             = word[synth_prog_pkg::A_LSB +: synth_prog_pkg::A_W];
            st_nxt.div.dual_modulus_select = word[synth_prog_pkg::PSC_LSB +: 2];
            if (word[synth_prog_pkg::APPLY_BIT]) begin
              st_nxt.b_act   = word[synth_prog_pkg::B_LSB +: synth_prog_pkg::B_W];
              st_nxt.a_act   = word[synth_prog_pkg::A_LSB +: synth_prog_pkg::A_W];
              st_nxt.mod_act = mod_dec;
              st_nxt.lk_st   = synth_prog_pkg::LK_WAIT;
            end
          end
        end
        default: ;
      endcase
    end

    // Registered decodes for the pins
    st_nxt.lock_pin  = (st_r.div.observe_select == synth_prog_pkg::OBS_LOCK) & st_r.lock_sync[1];
    st_nxt.driver_on = st_r.ctrl.driver_control_source ? st_r.pin_sync[1]
                                                       : ~st_r.ctrl.output_driver_off;
    case (st_r.ctrl.output_mode)
      2'h1:    st_nxt.out_div = synth_prog_pkg::ODIV_2;
      2'h2:    st_nxt.out_div = synth_prog_pkg::ODIV_4;
      default: st_nxt.out_div = synth_prog_pkg::ODIV_1;
    endcase
    case (st_r.ctrl.antibacklash_width)
      2'h0:    st_nxt.backlash_ps = synth_prog_pkg::BACKLASH_PS_00;
      2'h1:    st_nxt.backlash_ps = synth_prog_pkg::BACKLASH_PS_01;
      2'h2:    st_nxt.backlash_ps = synth_prog_pkg::BACKLASH_PS_10;
      default: st_nxt.backlash_ps = synth_prog_pkg::BACKLASH_PS_11;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_r              <= '0;
      st_r.ctrl         <= synth_prog_pkg::CTRL_RST;
      st_r.cal          <= synth_prog_pkg::CAL_RST;
      st_r.div          <= synth_prog_pkg::DIV_RST;
      st_r.b_act        <= synth_prog_pkg::DIV_RST.b_count;
      st_r.mod_act      <= synth_prog_pkg::MOD_8;
      st_r.cal_required <= 1'b1;
      st_r.driver_on    <= 1'b1;
      st_r.out_div      <= synth_prog_pkg::ODIV_1;
      st_r.backlash_ps  <= synth_prog_pkg::BACKLASH_PS_00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cal_required_out    = st_r.cal_required;
  assign cal_busy_out        = st_r.cal.start;
  assign ctrl_out            = st_r.ctrl;
  assign cal_out             = st_r.cal;
  assign div_out             = st_r.div;
  assign b_active_out        = st_r.b_act;
  assign a_active_out        = st_r.a_act;
  assign modulus_active_out  = st_r.mod_act;
  assign antibacklash_ps_out = st_r.backlash_ps;
  assign output_divide_out   = st_r.out_div;
  assign driver_on_out       = st_r.driver_on;
  assign lock_detect_out     = st_r.lock_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence load_to(logic [3:0] code);
    load && (addr == code);
  endsequence

  sequence cal_running;
    st_r.cal_st == synth_prog_pkg::CAL_RUN;
  endsequence

  ctrl_word_load_a: assert property (load_to(synth_prog_pkg::ADDR_CTRL) ##0 !word[4]
      |=> ctrl_out.input_divider_ratio == $past(word[25:12]) && ctrl_out.pump_output_hiz == $past(word[29]))
    else $error("control word not loaded on strobe");
  soft_reset_a: assert property (load_to(synth_prog_pkg::ADDR_CTRL) ##0 word[4]
      |=> ctrl_out == synth_prog_pkg::CTRL_RST && div_out == synth_prog_pkg::DIV_RST && !cal_busy_out)
    else $error("soft reset did not restore defaults");
  addr_ignore_a: assert property (load && addr > 4'h2
      |=> $stable(ctrl_out) && $stable(cal_out) && $stable(div_out))
    else $error("unmapped address changed a register");
  cal_start_a: assert property (load_to(synth_prog_pkg::ADDR_CAL) ##0 word[31] && !cal_busy_out
      |=> cal_busy_out && cal_out.target_vco_mhz == $past(word[30:18]))
    else $error("calibration did not start");
  cal_finish_a: assert property (cal_running ##0 st_r.cal_cnt == CAL_LAST
      |=> !cal_busy_out && !cal_required_out)
    else $error("calibration did not end on time");
  cal_block_a: assert property (cal_running ##0 load && addr inside {4'h1, 4'h2}
      |=> $stable(div_out) && $stable(cal_out.target_vco_mhz))
    else $error("write accepted during calibration");
  div_apply_a: assert property (load_to(synth_prog_pkg::ADDR_DIV) ##0 word[29] && !cal_busy_out
      |=> b_active_out == $past(word[24:12]) && a_active_out == $past(word[11:6]) && div_out.apply_and_lock)
    else $error("apply did not load active dividers");
  lock_clear_a: assert property (st_r.lk_st == synth_prog_pkg::LK_WAIT && st_r.lock_sync[1] && !load
      |=> !div_out.apply_and_lock)
    else $error("apply bit not cleared on lock");
  observe_pin_a: assert property (div_out.observe_select != synth_prog_pkg::OBS_LOCK
      |=> !lock_detect_out)
    else $error("lock pin active without observe code");
  driver_source_a: assert property (ctrl_out.driver_control_source == 1'b0
      |=> driver_on_out == !$past(ctrl_out.output_driver_off))
    else $error("driver state does not follow control bit");

  sequence apply_accepted;
    load_to(synth_prog_pkg::ADDR_DIV) ##0 word[synth_prog_pkg::APPLY_BIT] && st_r.cal_st != synth_prog_pkg::CAL_RUN;
  endsequence

  odiv_one_a: assert property (ctrl_out.output_mode == 2'h0
      |=> output_divide_out == synth_prog_pkg::ODIV_1)
    else $error("output divide code 00 wrong");
  odiv_two_a: assert property (ctrl_out.output_mode == 2'h1
      |=> output_divide_out == synth_prog_pkg::ODIV_2)
    else $error("output divide code 01 wrong");
  odiv_four_a: assert property (ctrl_out.output_mode == 2'h2
      |=> output_divide_out == synth_prog_pkg::ODIV_4)
    else $error("output divide code 10 wrong");
  backlash_narrow_a: assert property (ctrl_out.antibacklash_width == 2'h1
      |=> antibacklash_ps_out == synth_prog_pkg::BACKLASH_PS_01)
    else $error("antibacklash code 01 wrong");
  backlash_wide_a: assert property (ctrl_out.antibacklash_width == 2'h2
      |=> antibacklash_ps_out == synth_prog_pkg::BACKLASH_PS_10)
    else $error("antibacklash code 10 wrong");
  cal_req_sticky_a: assert property (!cal_required_out
      |=> !cal_required_out)
    else $error("calibration flag set again");
  lock_pin_on_a: assert property (div_out.observe_select == synth_prog_pkg::OBS_LOCK && st_r.lock_sync[1]
      |=> lock_detect_out)
    else $error("lock pin not showing lock");
  driver_pin_a: assert property (ctrl_out.driver_control_source
      |=> driver_on_out == $past(st_r.pin_sync[1]))
    else $error("driver state does not follow pin");
  psc_code0_a: assert property (apply_accepted ##0 word[synth_prog_pkg::PSC_LSB +: 2] == 2'h0
      |=> modulus_active_out == synth_prog_pkg::MOD_8)
    else $error("prescaler code 00 wrong");
  psc_code1_a: assert property (apply_accepted ##0 word[synth_prog_pkg::PSC_LSB +: 2] == 2'h1
      |=> modulus_active_out == synth_prog_pkg::MOD_16)
    else $error("prescaler code 01 wrong");
  psc_code2_a: assert property (apply_accepted ##0 word[synth_prog_pkg::PSC_LSB +: 2] == 2'h2
      |=> modulus_active_out == synth_prog_pkg::MOD_32)
    else $error("prescaler code 10 wrong");
  psc_code3_a: assert property (apply_accepted ##0 word[synth_prog_pkg::PSC_LSB +: 2] == 2'h3
      |=> modulus_active_out == synth_prog_pkg::MOD_64)
    else $error("prescaler code 11 wrong");
  cal_count_bound_a: assert property (cal_running
      |-> st_r.cal_cnt <= CAL_LAST)
    else $error("calibration counter overran");

endmodule : synth_prog_regs

`default_nettype wire

//--- tb/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
  input  wire logic clk_sys_in,
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_load_out
);

  initial begin
    ser_clk_out  = 1'b0;
    ser_data_out = 1'b0;
    ser_load_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame: optional filler bits, then the word, then the strobe
  task automatic send_word(input logic [31:0] word, input int npre);
    #7;
    for (int i = -npre; i < 32; i++) begin
      ser_data_out = (i < 0) ? 1'b1 : word[i];
      #32 ser_clk_out = 1'b1;
      #32 ser_clk_out = 1'b0;
    end
    // Released line shows no stale value
    ser_data_out = ~ser_data_out;
    @(posedge clk_sys_in);
    ser_load_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    ser_load_out <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask : send_word

endmodule : host_link_model

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  localparam int unsigned CAL_N = 1000;

  logic                         clk_sys_in;
  logic                         sys_rst_in;
  logic                         ser_clk;
  logic                         ser_data;
  logic                         ser_load;
  logic                         lock_raw;
  logic                         drv_pin;
  logic                         cal_req;
  logic                         cal_busy;
  logic                         drv_on;
  logic                         lock_det;
  logic [12:0]                  b_act;
  logic [5:0]                   a_act;
  logic [6:0]                   mod_act;
  logic [11:0]                  backlash_ps;
  logic [2:0]                   odiv;
  synth_prog_pkg::ctrl_fields_t ctrl;
  synth_prog_pkg::ctrl_fields_t ce;
  synth_prog_pkg::cal_fields_t  cal;
  synth_prog_pkg::cal_fields_t  cale;
  synth_prog_pkg::div_fields_t  div;
  synth_prog_pkg::div_fields_t  de;
  int                           bad_count;
  int                           n_tests;

  host_link_model host (.clk_sys_in(clk_sys_in), .ser_clk_out(ser_clk), .ser_data_out(ser_data),
                        .ser_load_out(ser_load));

  synth_prog_regs #(.CAL_CYCLES(CAL_N)) uut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ser_clk_in(ser_clk), .ser_data_in(ser_data),
    .ser_load_in(ser_load), .lock_raw_in(lock_raw), .driver_enable_pin_in(drv_pin),
    .cal_required_out(cal_req), .cal_busy_out(cal_busy), .ctrl_out(ctrl), .cal_out(cal), .div_out(div),
    .b_active_out(b_act), .a_active_out(a_act), .modulus_active_out(mod_act),
    .antibacklash_ps_out(backlash_ps), .output_divide_out(odiv), .driver_on_out(drv_on),
    .lock_detect_out(lock_det));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic chk_regs;
    check("ctrl_out", 32'(ce), 32'(ctrl));
    check("cal_out", 32'(cale), 32'(cal));
    check("div_out", 32'(de), 32'(div));
  endtask : chk_regs

  task automatic chk_active(input logic [12:0] b, input logic [5:0] a, input logic [6:0] m);
    check("b_active", 32'(b), 32'(b_act));
    check("a_active", 32'(a), 32'(a_act));
    check("modulus", 32'(m), 32'(mod_act));
  endtask : chk_active

  task automatic wr(input logic [31:0] w, input int npre);
    host.send_word(w, npre);
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask : wr

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #150000;
    bad_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] bl_tab   [4];
    logic [2:0]  odiv_tab [4];
    logic [6:0]  mod_tab  [4];
    bl_tab   = '{synth_prog_pkg::BACKLASH_PS_00, synth_prog_pkg::BACKLASH_PS_01, synth_prog_pkg::BACKLASH_PS_10,
                 synth_prog_pkg::BACKLASH_PS_11};
    odiv_tab = '{synth_prog_pkg::ODIV_1, synth_prog_pkg::ODIV_2, synth_prog_pkg::ODIV_4, synth_prog_pkg::ODIV_1};
    mod_tab  = '{synth_prog_pkg::MOD_8, synth_prog_pkg::MOD_16, synth_prog_pkg::MOD_32, synth_prog_pkg::MOD_64};
    sys_rst_in = 1'b1;
    lock_raw   = 1'b0;
    drv_pin    = 1'b0;
    bad_count  = 0;
    n_tests    = 0;
    ce   = synth_prog_pkg::CTRL_RST;
    cale = synth_prog_pkg::CAL_RST;
    de   = synth_prog_pkg::DIV_RST;
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk_regs();
    chk_active(13'h0003, 6'h00, synth_prog_pkg::MOD_8);
    check("cal_required", 32'h1, 32'(cal_req));
    check("cal_busy", 32'h0, 32'(cal_busy));
    check("driver_on", 32'h1, 32'(drv_on));
    // Control fields, every antibacklash and output mode code; bit 31 and filler bits must not leak in
    for (int i = 0; i < 4; i++) begin
      ce.pump_pulse_test       = i[1];
      ce.pump_output_hiz       = (i == 3);
      ce.detector_polarity     = i[0];
      ce.antibacklash_width    = 2'(i);
      ce.input_divider_ratio   = (i == 3) ? 14'h3FFF : 14'(i + 1);
      ce.output_driver_off     = i[1];
      ce.driver_control_source = 1'b0;
      ce.output_mode           = 2'(i);
      ce.pump_current_select   = 3'(2 * i + 1);
      wr({(i == 0), ce, 1'b0, synth_prog_pkg::ADDR_CTRL}, (i == 1) ? 8 : 0);
      chk_regs();
      check("backlash_ps", 32'(bl_tab[i]), 32'(backlash_ps));
      check("out_div", 32'(odiv_tab[i]), 32'(odiv));
      check("driver_on", 32'(!i[1]), 32'(drv_on));
      check("cal_required", 32'h1, 32'(cal_req));
    end
    // Driver follows the pin when the source bit is set
    ce.driver_control_source = 1'b1;
    wr({1'b0, ce, 1'b0, synth_prog_pkg::ADDR_CTRL}, 0);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys_in);
      drv_pin <= p[0];
      repeat (5) @(posedge clk_sys_in);
      #1;
      check("driver_pin", 32'(p), 32'(drv_on));
    end
    // Unmapped addresses change nothing
    wr(32'hFFFFFFF3, 0);
    wr(32'hFFFFFFFF, 0);
    chk_regs();
    // Divider held back until the apply bit
    de = '{1'b0, 4'h6, 13'h1FFF, 6'h3F, 2'h3};
    wr({2'b00, de, synth_prog_pkg::ADDR_DIV}, 0);
    chk_regs();
    chk_active(13'h0003, 6'h00, synth_prog_pkg::MOD_8);
    check("lock_detect", 32'h0, 32'(lock_det));
    de.apply_and_lock = 1'b1;
    wr({2'b00, de, synth_prog_pkg::ADDR_DIV}, 0);
    chk_regs();
    chk_active(13'h1FFF, 6'h3F, synth_prog_pkg::MOD_64);
    @(posedge clk_sys_in);
    lock_raw <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1;
    de.apply_and_lock = 1'b0;
    chk_regs();
    check("lock_detect", 32'h1, 32'(lock_det));
    for (int p = 0; p < 4; p++) begin
      de = '{1'b1, (p == 2) ? 4'h6 : 4'h0, 13'(p + 3), 6'(p), 2'(p)};
      wr({2'b00, de, synth_prog_pkg::ADDR_DIV}, 0);
      de.apply_and_lock = 1'b0;
      chk_regs();
      chk_active(13'(p + 3), 6'(p), mod_tab[p]);
      check("lock_detect", 32'(p == 2), 32'(lock_det));
    end
    // Calibration; divider write while busy is refused
    cale = '{1'b1, 13'h0708, 7'h1E, 7'h48};
    wr({cale, synth_prog_pkg::ADDR_CAL}, 0);
    check("cal_busy", 32'h1, 32'(cal_busy));
    wr(32'h3FFFFFF2, 0);
    chk_regs();
    check("cal_busy", 32'h1, 32'(cal_busy));
    for (int k = 0; k < 2000 && cal_busy === 1'b1; k++) @(posedge clk_sys_in);
    repeat (2) @(posedge clk_sys_in);
    #1;
    cale.start = 1'b0;
    chk_regs();
    check("cal_required", 32'h0, 32'(cal_req));
    // Soft reset word restores register defaults except cal_required, and is not stored
    wr({1'b0, 26'h3FFFFFF, 1'b1, synth_prog_pkg::ADDR_CTRL}, 0);
    ce   = synth_prog_pkg::CTRL_RST;
    cale = synth_prog_pkg::CAL_RST;
    de   = synth_prog_pkg::DIV_RST;
    chk_regs();
    chk_active(13'h0003, 6'h00, synth_prog_pkg::MOD_8);
    check("cal_required", 32'h0, 32'(cal_req));
    close_out();
  end

endmodule : tb_top

`default_nettype wire
